// [design/buck_supervisor_pkg.sv]
// Constants, carrier structs and state layout of the buck supervisor.
// Assumes one 100 MHz clock and comparator results already synchronous.
package buck_supervisor_pkg;

    localparam int unsigned CLK_PERIOD_NS = 10;
    localparam int unsigned SETTLE_NS     = 400;
    localparam int unsigned MASK_US       = 100;
    localparam int unsigned OCP_MS        = 7;
    localparam int unsigned STEP_NS       = 1000;
    // Least times round up
    localparam int unsigned SETTLE_CYC =
        (SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned MASK_CYC =
        (MASK_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned OCP_CYC =
        (OCP_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned STEP_CYC =
        (STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    localparam logic [6:0]  CODE_TOP   = 7'h01;
    localparam logic [6:0]  CODE_LOW   = 7'h59;
    localparam logic [6:0]  CODE_OFF   = 7'h7F;
    localparam logic [15:0] SET_TOP    = 16'h3E80; // 1.6000 V in 0.1 mV
    localparam logic [15:0] SET_STEP   = 16'h007D; // 12.5 mV in 0.1 mV

    localparam logic [5:0]  SETTLE_RST = 6'h00;
    localparam logic [15:0] MASK_RST   = 16'h0000;
    localparam logic [19:0] OCP_RST    = 20'h00000;
    localparam logic [6:0]  STEP_RST   = 7'h00;

    typedef enum logic [2:0] {
        ST_SHUTDOWN = 3'h1,
        ST_RUN      = 3'h2,
        ST_LATCHED  = 3'h4
    } mode_e;

    typedef struct packed {
        logic ov_trip;      // output above overvoltage threshold
        logic rv_below_lo;  // sense node below -190 mV
        logic rv_above_hi;  // sense node above -150 mV
        logic rv_above_pos; // sense node above +50 mV
        logic pg_window_ok; // output inside power-good window
        logic overcurrent;  // current limit engaged
    } comp_s;

    typedef struct packed {
        mode_e       mode;
        logic        reverse_voltage_guard;
        logic        latch_rv_off;
        logic [6:0]  code_seen;
        logic [6:0]  code_target;
        logic [6:0]  code_cur;
        logic [5:0]  settle_cnt;
        logic [15:0] mask_cnt;
        logic [19:0] ocp_cnt;
        logic [6:0]  step_cnt;
        logic        high_side_gate_cmd;
        logic        low_side_gate_cmd;
        logic        power_good_out;
        logic        discharge;
    } sup_s;

endpackage

// [design/buck_supervisor.sv]
// Supervisory logic: crowbar, latch-off, reverse protection, shutdown,
// code settling, soft code stepping and setpoint decode.
// Assumes every input is synchronous to mclk; no registers are reachable.
`timescale 1ns/1ps
module buck_supervisor #(
    parameter int unsigned MASK_CYCLES = buck_supervisor_pkg::MASK_CYC,
    parameter int unsigned OCP_CYCLES  = buck_supervisor_pkg::OCP_CYC
) (
    input  wire logic                        mclk,
    input  wire logic                        rst,
    input  wire logic                        supply_ok_flag,
    input  wire logic                        supply_lockout_flag,
    input  wire logic                        enable_in,
    input  wire buck_supervisor_pkg::comp_s  comp,
    input  wire logic                        pwm_high_req,
    input  wire logic [6:0]                  voltage_code,
    output logic                             high_side_gate_cmd,
    output logic                             low_side_gate_cmd,
    output logic                             power_good_out,
    output logic                             soft_start_discharge,
    output logic                             power_good_delay_cap_discharge,
    output logic [6:0]                       dac_code,
    output logic                             dac_output_off,
    output logic [15:0]                      dac_setpoint,
    output logic                             latched_off
);

    buck_supervisor_pkg::sup_s st;
    buck_supervisor_pkg::sup_s next_st;
    logic                      shut_req;
    logic                      cur_off;
    logic                      tgt_off;

    function automatic logic code_is_off(input logic [6:0] c);
        // Zero and every code past the lowest setpoint mean off
        code_is_off = (c == 7'h00) || (c > buck_supervisor_pkg::CODE_LOW);
    endfunction

    always_comb begin
        next_st  = st;
        shut_req = supply_lockout_flag || !enable_in || !supply_ok_flag;
        cur_off  = code_is_off(st.code_cur);
        tgt_off  = code_is_off(st.code_target);

        // Code settling: any change restarts the wait to ride out bit skew
        if (voltage_code != st.code_seen) begin
            next_st.code_seen  = voltage_code;
            next_st.settle_cnt = 6'(buck_supervisor_pkg::SETTLE_CYC);
        end else if (st.settle_cnt != buck_supervisor_pkg::SETTLE_RST) begin
            next_st.settle_cnt = st.settle_cnt - 6'h01;
            if (st.settle_cnt == 6'h01) begin
                next_st.code_target = st.code_seen;
                if (st.code_seen != st.code_target) begin
                    next_st.mask_cnt = 16'(MASK_CYCLES);
                end
            end
        end

        // Soft transient: one code per step tick; off is entered directly
        if (st.code_cur != st.code_target) begin
            if (cur_off || tgt_off) begin
                next_st.code_cur = st.code_target;
                next_st.step_cnt = buck_supervisor_pkg::STEP_RST;
            end else if (st.step_cnt == 7'(buck_supervisor_pkg::STEP_CYC - 1))
            begin
                next_st.step_cnt = buck_supervisor_pkg::STEP_RST;
                if (st.code_cur < st.code_target) begin
                    next_st.code_cur = st.code_cur + 7'h01;
                end else begin
                    next_st.code_cur = st.code_cur - 7'h01;
                end
            end else begin
                next_st.step_cnt = st.step_cnt + 7'h01;
            end
        end else begin
            next_st.step_cnt = buck_supervisor_pkg::STEP_RST;
        end

        if (st.mask_cnt != buck_supervisor_pkg::MASK_RST &&
            next_st.mask_cnt == st.mask_cnt) begin
            next_st.mask_cnt = st.mask_cnt - 16'h0001;
        end

        // Reverse guard with hysteresis between the two thresholds
        if (comp.rv_below_lo) begin
            next_st.reverse_voltage_guard = 1'b1;
        end else if (comp.rv_above_hi) begin
            next_st.reverse_voltage_guard = 1'b0;
        end

        case (st.mode)
            buck_supervisor_pkg::ST_SHUTDOWN: begin
                next_st.high_side_gate_cmd = 1'b0;
                next_st.low_side_gate_cmd  = 1'b0;
                next_st.power_good_out     = 1'b0;
                next_st.discharge          = 1'b1;
                next_st.ocp_cnt            = buck_supervisor_pkg::OCP_RST;
                next_st.latch_rv_off       = 1'b0;
                if (!shut_req) begin
                    next_st.mode      = buck_supervisor_pkg::ST_RUN;
                    next_st.discharge = 1'b0;
                    next_st.mask_cnt  = 16'(MASK_CYCLES);
                end
            end
            buck_supervisor_pkg::ST_RUN: begin
                next_st.discharge = 1'b0;
                if (st.mask_cnt == buck_supervisor_pkg::MASK_RST) begin
                    next_st.power_good_out = comp.pg_window_ok && !cur_off;
                end
                if (comp.overcurrent && !st.power_good_out &&
                    st.mask_cnt == buck_supervisor_pkg::MASK_RST) begin
                    next_st.ocp_cnt = st.ocp_cnt + 20'h00001;
                end else begin
                    next_st.ocp_cnt = buck_supervisor_pkg::OCP_RST;
                end
                if (comp.ov_trip) begin
                    next_st.high_side_gate_cmd = 1'b0;
                    next_st.low_side_gate_cmd  = 1'b1;
                end else if (next_st.reverse_voltage_guard || cur_off) begin
                    next_st.high_side_gate_cmd = 1'b0;
                    next_st.low_side_gate_cmd  = 1'b0;
                end else begin
                    next_st.high_side_gate_cmd = pwm_high_req;
                    next_st.low_side_gate_cmd  = !pwm_high_req;
                end
                if (comp.ov_trip ||
                    st.ocp_cnt == 20'(OCP_CYCLES - 1)) begin
                    next_st.mode           = buck_supervisor_pkg::ST_LATCHED;
                    next_st.power_good_out = 1'b0;
                    next_st.latch_rv_off   = comp.rv_below_lo && !comp.ov_trip;
                    next_st.low_side_gate_cmd =
                        comp.ov_trip || !comp.rv_below_lo;
                end
            end
            buck_supervisor_pkg::ST_LATCHED: begin
                // Crowbar held; reverse monitor still guards the low side
                next_st.high_side_gate_cmd = 1'b0;
                next_st.power_good_out     = 1'b0;
                next_st.ocp_cnt            = buck_supervisor_pkg::OCP_RST;
                if (comp.rv_below_lo) begin
                    next_st.latch_rv_off = 1'b1;
                end else if (comp.rv_above_pos) begin
                    next_st.latch_rv_off = 1'b0;
                end
                next_st.low_side_gate_cmd = !next_st.latch_rv_off;
            end
            default: begin
                next_st.mode = buck_supervisor_pkg::ST_SHUTDOWN;
            end
        endcase

        // Supply loss or enable low overrides everything and clears latch
        if (shut_req) begin
            next_st.mode               = buck_supervisor_pkg::ST_SHUTDOWN;
            next_st.high_side_gate_cmd = 1'b0;
            next_st.low_side_gate_cmd  = 1'b0;
            next_st.power_good_out     = 1'b0;
            next_st.discharge          = 1'b1;
            next_st.latch_rv_off       = 1'b0;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            st             <= '0;
            st.mode        <= buck_supervisor_pkg::ST_SHUTDOWN;
            st.code_seen   <= buck_supervisor_pkg::CODE_OFF;
            st.code_target <= buck_supervisor_pkg::CODE_OFF;
            st.code_cur    <= buck_supervisor_pkg::CODE_OFF;
            st.discharge   <= 1'b1;
        end else begin
            st <= next_st;
        end
    end

    assign high_side_gate_cmd             = st.high_side_gate_cmd;
    assign low_side_gate_cmd              = st.low_side_gate_cmd;
    assign power_good_out                 = st.power_good_out;
    assign soft_start_discharge           = st.discharge;
    assign power_good_delay_cap_discharge = st.discharge;
    assign dac_code                       = st.code_cur;
    assign dac_output_off                 = cur_off;
    assign latched_off = (st.mode == buck_supervisor_pkg::ST_LATCHED);
    assign dac_setpoint = cur_off ? 16'h0000 :
        16'(buck_supervisor_pkg::SET_TOP - 16'(st.code_cur - 7'h01)
            * buck_supervisor_pkg::SET_STEP);

    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    chk_ov_crowbar: assert property (
        (st.mode == buck_supervisor_pkg::ST_RUN && comp.ov_trip && !shut_req)
        |=> (low_side_gate_cmd && !high_side_gate_cmd && latched_off))
        else $error("overvoltage did not crowbar");
    chk_latch_holds: assert property (
        (latched_off && !shut_req) |=> latched_off && !high_side_gate_cmd)
        else $error("latch-off released without shutdown");
    chk_latch_clear: assert property (
        (latched_off && !enable_in) |=> !latched_off && discharge_both())
        else $error("enable low did not clear latch");
    chk_rv_both_low: assert property (
        (st.mode == buck_supervisor_pkg::ST_RUN && comp.rv_below_lo &&
         !comp.ov_trip && !shut_req)
        |=> !high_side_gate_cmd && !low_side_gate_cmd)
        else $error("reverse trip left a gate on");
    chk_rv_hyst: assert property (
        (st.reverse_voltage_guard && !comp.rv_above_hi)
        |=> st.reverse_voltage_guard)
        else $error("reverse guard released early");
    chk_latch_rv_low: assert property (
        (latched_off && comp.rv_below_lo && !shut_req)
        |=> !low_side_gate_cmd)
        else $error("latched reverse trip kept low side on");
    chk_latch_rv_back: assert property (
        (latched_off && !comp.rv_below_lo && comp.rv_above_pos && !shut_req)
        |=> low_side_gate_cmd)
        else $error("low side not restored above recovery level");
    chk_shutdown_out: assert property (
        shut_req |=> !high_side_gate_cmd && !low_side_gate_cmd &&
                     !power_good_out && discharge_both())
        else $error("shutdown outputs wrong");
    chk_settle_wait: assert property (
        (voltage_code != st.code_seen)
        |=> (st.code_target == $past(st.code_target)) [*8])
        else $error("code accepted before settling");
    chk_step_one: assert property (
        (!cur_off && !code_is_off(next_st.code_cur))
        |=> (dac_code - $past(dac_code) == 7'h01 ||
             $past(dac_code) - dac_code == 7'h01 ||
             dac_code == $past(dac_code)))
        else $error("setpoint skipped a code");

    function automatic logic discharge_both();
        discharge_both = soft_start_discharge && power_good_delay_cap_discharge;
    endfunction

endmodule

// [testbench/power_stage_model.sv]
// Power stage and output sense comparators beside the buck supervisor.
// Assumes the bench sets the sensed output level in millivolts.
`timescale 1ns/1ps
module power_stage_model #(
    parameter logic signed [15:0] OV_MV = 16'sh0708
) (
    input  wire logic                      mclk,
    input  wire logic signed [15:0]        sense_mv,
    input  wire logic                      pg_in,
    input  wire logic                      oc_in,
    output buck_supervisor_pkg::comp_s     comp
);
    localparam logic signed [15:0] RV_LO  = 16'shFF42; // -190 mV
    localparam logic signed [15:0] RV_HI  = 16'shFF6A; // -150 mV
    localparam logic signed [15:0] RV_POS = 16'sh0032; // +50 mV
    // Registered like a comparator bank, so every result lags one cycle
    always_ff @(posedge mclk) begin
        comp.ov_trip      <= sense_mv > OV_MV;
        comp.rv_below_lo  <= sense_mv < RV_LO;
        comp.rv_above_hi  <= sense_mv > RV_HI;
        comp.rv_above_pos <= sense_mv > RV_POS;
        comp.pg_window_ok <= pg_in;
        comp.overcurrent  <= oc_in;
    end
endmodule

// [testbench/testbench.sv]
// Self-checking bench for the buck supervisor with a power stage model.
// Assumes short mask and overcurrent counts set at the instance.
`timescale 1ns/1ps
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin \
    n_mismatch++; $display("FAIL t=%0t got=%h exp=%h", $time, a, e); \
    end end
module testbench;
    logic                       mclk, rst, sok, lock, en, pwm, pg, oc;
    logic [6:0]                 code, dac_code;
    logic signed [15:0]         sense;
    buck_supervisor_pkg::comp_s comp;
    logic                       hi, lo, pgo, ss, pgd, off, latched;
    logic [15:0]                setp;
    int                         n_mismatch, checks_done;

    power_stage_model power_stage_model_i (.mclk(mclk), .sense_mv(sense),
        .pg_in(pg), .oc_in(oc), .comp(comp));
    buck_supervisor #(.MASK_CYCLES(20), .OCP_CYCLES(50)) buck_supervisor_i (
        .mclk(mclk), .rst(rst), .supply_ok_flag(sok),
        .supply_lockout_flag(lock), .enable_in(en), .comp(comp),
        .pwm_high_req(pwm), .voltage_code(code), .high_side_gate_cmd(hi),
        .low_side_gate_cmd(lo), .power_good_out(pgo),
        .soft_start_discharge(ss), .power_good_delay_cap_discharge(pgd),
        .dac_code(dac_code), .dac_output_off(off), .dac_setpoint(setp),
        .latched_off(latched));

    always #5 mclk = ~mclk;

    task automatic cyc(input int n);
        repeat (n) @(posedge mclk);
    endtask
    // Waits n edges, then settles to the falling edge for sampling
    task automatic look(input int n);
        cyc(n);
        @(negedge mclk);
    endtask
    function automatic logic [15:0] exp_set(input logic [6:0] c);
        if (c >= 7'h01 && c <= 7'h59)
            return 16'h3E80 - 16'(c - 7'h01) * 16'h007D;
        return 16'h0000;
    endfunction
    task automatic chk_shut();
        `CHK(hi, 1'b0)
        `CHK(lo, 1'b0)
        `CHK(pgo, 1'b0)
        `CHK({ss, pgd}, 2'h3)
    endtask
    // Walks to an on code, checking settle delay, single steps and decode
    task automatic go_code(input logic [6:0] c);
        logic [6:0] prev;
        cyc(1);
        prev = dac_code;
        code <= c;
        for (int i = 0; i < 12000 && dac_code !== c; i++) begin
            @(negedge mclk);
            if (i < 39) `CHK(dac_code, prev)
            `CHK(setp, exp_set(dac_code))
            if (dac_code != prev && exp_set(prev) != 0 && exp_set(dac_code)
                != 0) `CHK(7'(dac_code - prev + 7'h01) <= 7'h02, 1'b1)
            prev = dac_code;
        end
        `CHK(dac_code, c)
        `CHK(off, 1'b0)
    endtask

    task automatic t_start();
        cyc(1);
        sok <= 1'b1;
        lock <= 1'b0;
        sense <= 16'sh04B0; // 1200 mV
        look(4);
        `CHK({ss, pgd}, 2'h3)
        cyc(1);
        en <= 1'b1;
        pwm <= 1'b1;
        look(4);
        `CHK({ss, pgd}, 2'h0)
        `CHK(hi, 1'b0)
        $display("test start done");
    endtask
    task automatic t_codes();
        logic [6:0] offs [3] = '{7'h5A, 7'h7F, 7'h00};
        go_code(7'h01);
        go_code(7'h03);
        go_code(7'h59);
        foreach (offs[k]) begin
            cyc(1);
            code <= offs[k];
            look(45);
            `CHK({off, setp}, 17'h10000)
        end
        go_code(7'h20);
        look(3);
        `CHK(hi, 1'b1)
        $display("test codes done");
    endtask
    task automatic t_protect();
        cyc(1);
        sense <= 16'sh076C; // 1900 mV, above overvoltage
        look(3);
        `CHK({hi, lo, latched}, 3'h3)
        cyc(1);
        sense <= 16'sh04B0;
        look(6);
        `CHK({hi, lo, latched}, 3'h3)
        cyc(1);
        sense <= 16'shFF38; // -200 mV
        look(3);
        `CHK({hi, lo, latched}, 3'h1)
        cyc(1);
        sense <= 16'sh0000; // between release and recovery levels
        look(3);
        `CHK(lo, 1'b0)
        cyc(1);
        sense <= 16'sh0064; // +100 mV
        look(3);
        `CHK(lo, 1'b1)
        cyc(1);
        en <= 1'b0;
        look(3);
        chk_shut();
        cyc(1);
        en <= 1'b1;
        pg <= 1'b1;
        look(4);
        `CHK({hi, latched, ss}, 3'h4)
        `CHK(pgo, 1'b0)
        $display("test protect done");
    endtask
    task automatic t_reverse();
        cyc(1);
        sense <= 16'shFF38; // -200 mV
        look(3);
        `CHK({hi, lo}, 2'h0)
        cyc(1);
        sense <= 16'shFF56; // -170 mV, inside hysteresis
        look(4);
        `CHK({hi, lo}, 2'h0)
        cyc(1);
        sense <= 16'shFF9C; // -100 mV
        look(3);
        `CHK(hi, 1'b1)
        $display("test reverse done");
    endtask
    task automatic t_ocp();
        cyc(30);
        pg <= 1'b1;
        look(3);
        `CHK(pgo, 1'b1)
        cyc(1);
        pg <= 1'b0;
        oc <= 1'b1;
        look(32);
        `CHK({pgo, latched}, 2'h0)
        look(30);
        `CHK(latched, 1'b1)
        cyc(1);
        oc <= 1'b0;
        lock <= 1'b1;
        look(3);
        chk_shut();
        `CHK(latched, 1'b0)
        $display("test overcurrent and lockout done");
    endtask

    task automatic results();
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    initial begin
        #500000;
        n_mismatch++;
        results();
    end
    initial begin
        mclk = 1'b0; rst = 1'b1; sok = 1'b0; lock = 1'b1; en = 1'b0;
        pwm = 1'b0; pg = 1'b0; oc = 1'b0; sense = 16'sh0000;
        code = 7'h00;
        n_mismatch = 0;
        checks_done = 0;
        cyc(6);
        rst <= 1'b0;
        look(1);
        chk_shut();
        `CHK({dac_code, off, setp, latched}, 25'h1FE0000)
        t_start();
        t_codes();
        t_protect();
        t_reverse();
        t_ocp();
        results();
    end
endmodule
